// >>> rtl/uart_baud_fifo_irq.sv
// Serial port baud generation and FIFO-mode interrupt logic, AXI4-Lite registers
// Notes on behaviour
// - Divisor 1..65535 gives 16x baud clock
// - Divisor held as low and high bytes
// - Divisor byte write reloads baud counter
// - Divisor zero divides input clock by three
// - Divisor one outputs inverted oscillator
// - Divisor two gives half-duty divide by two
// - Three or more: low two, high rest
// - High-speed bit: 32770 doubles, 32769 quadruples
// - Trigger level raises receive data interrupt
// - Line status beats received data
// - Data ready sets on push, clears empty
// - Timeout after four idle character times
// - Timeout counted on receive baud clock
// - CPU read clears timeout, restarts timer
// - Timer restarts on receive or read
// - Transmit empty interrupt; write or identification-read clears
// - Empty indication delayed after single byte
// - FIFO enable change raises transmit interrupt
// - Timeout ranks below received data; empty shares holding
// - Divisor reachable only with latch access set
`timescale 1ns/1ps
module uart_baud_fifo_irq #(
  parameter int unsigned OSC_HALF = uart_pkg::OSC_HALF_CYCLES,
  parameter int unsigned FIFO_DEPTH = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [5:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [5:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic rx_push,
  input wire logic [4:0] rx_level,
  input wire logic [7:0] rx_data,
  input wire logic [3:0] rx_err_bits,
  input wire logic rx_fifo_err,
  output logic rx_pop,
  input wire logic [4:0] tx_level,
  input wire logic tx_idle,
  output logic tx_push,
  output logic [7:0] tx_wdata,
  output logic line_status_read,
  output logic rx_fifo_clear,
  output logic tx_fifo_clear,
  output logic baud16,
  output logic baud_tick,
  output logic uart_irq
);
  // ---------------------------------------------------------------
  // Parameter checks
  // ---------------------------------------------------------------
  if (OSC_HALF < 4 || OSC_HALF > 255) begin : g_bad_osc
    $error("OSC_HALF must be 4..255");
  end
  if (FIFO_DEPTH != 16) begin : g_bad_depth
    $error("FIFO_DEPTH must be 16 to match the level ports");
  end

  // ---------------------------------------------------------------
  // Register state
  // ---------------------------------------------------------------
  logic [15:0] div_ff;
  logic [7:0] ien_ff, fcr_ff, lctl_ff;
  logic hs_ff;
  logic aw_held_ff, w_held_ff;
  logic [3:0] aw_idx_ff;
  logic [7:0] wbyte_ff;
  logic wlane_ff;
  logic [1:0] bresp_ff, rresp_ff;
  logic bvalid_ff, rvalid_ff;
  logic [31:0] rdata_ff;
  logic rx_pop_ff, tx_push_ff, lsr_rd_ff, rxclr_ff, txclr_ff;
  logic [7:0] tx_wdata_ff;

  logic latch_access_bit, fifo_en;
  assign latch_access_bit = lctl_ff[uart_pkg::LATCH_ACCESS_BIT];
  assign fifo_en = fcr_ff[uart_pkg::FCR_EN_BIT];

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic wr_go, wr_en, wr_map;
  logic wr_div_lo, wr_div_hi, wr_thr, wr_ien, wr_fcr, wr_lctl, wr_cfg;
  assign awready = !aw_held_ff && !bvalid_ff;
  assign wready = !w_held_ff && !bvalid_ff;
  assign wr_go = aw_held_ff && w_held_ff;
  assign wr_en = wr_go && wlane_ff;
  assign wr_div_lo = wr_en && aw_idx_ff == uart_pkg::IDX_DATA && latch_access_bit;
  assign wr_thr = wr_en && aw_idx_ff == uart_pkg::IDX_DATA && !latch_access_bit;
  assign wr_div_hi = wr_en && aw_idx_ff == uart_pkg::IDX_IEN && latch_access_bit;
  assign wr_ien = wr_en && aw_idx_ff == uart_pkg::IDX_IEN && !latch_access_bit;
  assign wr_fcr = wr_en && aw_idx_ff == uart_pkg::IDX_IID;
  assign wr_lctl = wr_en && aw_idx_ff == uart_pkg::IDX_LCTL;
  assign wr_cfg = wr_en && aw_idx_ff == uart_pkg::IDX_CFG;
  assign wr_map = aw_idx_ff == uart_pkg::IDX_DATA || aw_idx_ff == uart_pkg::IDX_IEN ||
                  aw_idx_ff == uart_pkg::IDX_IID || aw_idx_ff == uart_pkg::IDX_LCTL ||
                  aw_idx_ff == uart_pkg::IDX_LSTAT || aw_idx_ff == uart_pkg::IDX_CFG;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      aw_idx_ff <= 4'h0;
      wbyte_ff <= uart_pkg::REG8_RESET;
      wlane_ff <= 1'b0;
      bvalid_ff <= 1'b0;
      bresp_ff <= uart_pkg::RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_held_ff <= 1'b1;
        aw_idx_ff <= awaddr[5:2];
      end else if (wr_go) begin
        aw_held_ff <= 1'b0;
      end
      if (wvalid && wready) begin
        w_held_ff <= 1'b1;
        wbyte_ff <= wdata[7:0];
        wlane_ff <= wstrb[0];
      end else if (wr_go) begin
        w_held_ff <= 1'b0;
      end
      if (wr_go) begin
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_map ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
      end else if (bready) begin
        bvalid_ff <= 1'b0;
      end
    end
  end
  assign bvalid = bvalid_ff;
  assign bresp = bresp_ff;

  // ---------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= uart_pkg::DIV_RESET;
      ien_ff <= uart_pkg::REG8_RESET;
      fcr_ff <= uart_pkg::REG8_RESET;
      lctl_ff <= uart_pkg::REG8_RESET;
      hs_ff <= 1'b0;
    end else begin
      if (wr_div_lo) div_ff[7:0] <= wbyte_ff;
      if (wr_div_hi) div_ff[15:8] <= wbyte_ff;
      if (wr_ien) ien_ff <= {4'h0, wbyte_ff[3:0]};
      if (wr_fcr) fcr_ff <= {wbyte_ff[7:6], 3'h0, wbyte_ff[2:0]};
      if (wr_lctl) lctl_ff <= wbyte_ff;
      if (wr_cfg) hs_ff <= wbyte_ff[uart_pkg::CFG_HS_BIT];
    end
  end

  // Side-effect pulses to the FIFO logic, one cycle after the access
  logic fifo_enable_bit_chg, rd_go, rd_rbr, rd_iid, rd_lsr;
  assign fifo_enable_bit_chg = wr_fcr && (wbyte_ff[uart_pkg::FCR_EN_BIT] != fifo_en);
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tx_push_ff <= 1'b0;
      tx_wdata_ff <= uart_pkg::REG8_RESET;
      rx_pop_ff <= 1'b0;
      lsr_rd_ff <= 1'b0;
      rxclr_ff <= 1'b0;
      txclr_ff <= 1'b0;
    end else begin
      tx_push_ff <= wr_thr;
      if (wr_thr) tx_wdata_ff <= wbyte_ff;
      rx_pop_ff <= rd_rbr;
      lsr_rd_ff <= rd_lsr;
      // Changing the FIFO enable empties both FIFOs as well
      rxclr_ff <= wr_fcr && (wbyte_ff[uart_pkg::FCR_RXRST_BIT] || fifo_enable_bit_chg);
      txclr_ff <= wr_fcr && (wbyte_ff[uart_pkg::FCR_TXRST_BIT] || fifo_enable_bit_chg);
    end
  end
  assign tx_push = tx_push_ff;
  assign tx_wdata = tx_wdata_ff;
  assign rx_pop = rx_pop_ff;
  assign line_status_read = lsr_rd_ff;
  assign rx_fifo_clear = rxclr_ff;
  assign tx_fifo_clear = txclr_ff;

  // ---------------------------------------------------------------
  // Oscillator enable and baud generator
  // ---------------------------------------------------------------
  logic [7:0] osc_cnt_ff, osc_half;
  logic osc_lvl_ff, osc_rise;
  logic [15:0] eff_div;
  always_comb begin
    osc_half = 8'(OSC_HALF);
    eff_div = div_ff;
    if (hs_ff && div_ff == uart_pkg::DIV_HS_X2) begin
      // Both fast modes divide the faster oscillator by one
      osc_half = 8'(OSC_HALF >> 1);
      eff_div = 16'h0001;
    end else if (hs_ff && div_ff == uart_pkg::DIV_HS_X4) begin
      osc_half = 8'(OSC_HALF >> 2);
      eff_div = 16'h0001;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      osc_cnt_ff <= 8'h00;
      osc_lvl_ff <= 1'b0;
    end else if (osc_cnt_ff + 8'h01 >= osc_half) begin
      osc_cnt_ff <= 8'h00;
      osc_lvl_ff <= ~osc_lvl_ff;
    end else begin
      osc_cnt_ff <= 8'(osc_cnt_ff + 8'h01);
    end
  end
  assign osc_rise = !osc_lvl_ff && (osc_cnt_ff + 8'h01 >= osc_half);

  baud_generator u_baud (
    .aclk(aclk),
    .aresetn(aresetn),
    .osc_lvl(osc_lvl_ff),
    .osc_rise(osc_rise),
    .divisor(eff_div),
    .reload(wr_div_lo || wr_div_hi),
    .baud16(baud16),
    .baud_tick(baud_tick)
  );

  // ---------------------------------------------------------------
  // Character time from line settings
  // ---------------------------------------------------------------
  logic [3:0] char_bits;
  logic [7:0] char_ticks, tx_delay_ticks;
  logic [9:0] tmo_limit;
  assign char_bits = 4'(2 + uart_pkg::DATA_BITS_MIN) + {2'h0, lctl_ff[1:0]} +
                     {3'h0, lctl_ff[uart_pkg::PARITY_BIT]} +
                     {3'h0, lctl_ff[uart_pkg::STOP2_BIT]};
  assign char_ticks = 8'(char_bits * uart_pkg::TICKS_PER_BIT);
  // A second stop bit is part of the character and so of the idle time
  assign tmo_limit = 10'(char_ticks * uart_pkg::TIMEOUT_CHARS);
  assign tx_delay_ticks = 8'(char_ticks - 8'(uart_pkg::TICKS_PER_BIT));

  // ---------------------------------------------------------------
  // Receive side: data ready, trigger and timeout
  // ---------------------------------------------------------------
  logic dr_ff, tmo_ff;
  logic [9:0] tmo_cnt_ff;
  logic [4:0] trig;
  logic rda_hit, ls_hit, tmo_en;
  always_comb begin
    case (fcr_ff[7:6])
      2'h0: trig = uart_pkg::TRIG_L0;
      2'h1: trig = uart_pkg::TRIG_L1;
      2'h2: trig = uart_pkg::TRIG_L2;
      default: trig = uart_pkg::TRIG_L3;
    endcase
  end
  assign tmo_en = fifo_en && ien_ff[uart_pkg::IEN_RDA_BIT];
  assign rda_hit = tmo_en && rx_level >= trig;
  assign ls_hit = ien_ff[uart_pkg::IEN_RLS_BIT] && |rx_err_bits;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dr_ff <= 1'b0;
    end else if (rx_push) begin
      dr_ff <= 1'b1;
    end else if (rx_level == 5'h00) begin
      dr_ff <= 1'b0;
    end
  end

  // Timer runs on the 16x receive tick so it follows the baud rate
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tmo_cnt_ff <= 10'h000;
      tmo_ff <= 1'b0;
    end else if (!tmo_en || rx_level == 5'h00 || rd_rbr) begin
      tmo_cnt_ff <= 10'h000;
      tmo_ff <= 1'b0;
    end else if (rx_push && !tmo_ff) begin
      tmo_cnt_ff <= 10'h000;
    end else if (baud_tick && !tmo_ff) begin
      if (tmo_cnt_ff >= tmo_limit) begin
        tmo_ff <= 1'b1;
      end else begin
        tmo_cnt_ff <= 10'(tmo_cnt_ff + 10'h001);
      end
    end
  end

  // ---------------------------------------------------------------
  // Transmit side: holding-empty flag and its interrupt
  // ---------------------------------------------------------------
  logic holding_empty_flag_ff, two_seen_ff, holding_empty_flag_irq_ff, dly_on_ff, holding_empty_flag_set;
  logic [7:0] dly_cnt_ff;
  logic tx_empty;
  assign tx_empty = tx_level == 5'h00;
  logic dly_done;
  assign dly_done = dly_on_ff && baud_tick && dly_cnt_ff + 8'h01 >= tx_delay_ticks;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holding_empty_flag_ff <= 1'b1;
      two_seen_ff <= 1'b0;
      dly_on_ff <= 1'b0;
      dly_cnt_ff <= 8'h00;
    end else if (!tx_empty) begin
      holding_empty_flag_ff <= 1'b0;
      dly_on_ff <= 1'b0;
      if (tx_level >= 5'h02) two_seen_ff <= 1'b1;
    end else if (!holding_empty_flag_ff && !dly_on_ff) begin
      if (!two_seen_ff && fifo_en) begin
        dly_on_ff <= 1'b1;
        dly_cnt_ff <= 8'h00;
      end else begin
        holding_empty_flag_ff <= 1'b1;
        two_seen_ff <= 1'b0;
      end
    end else if (dly_on_ff && baud_tick) begin
      if (dly_cnt_ff + 8'h01 >= tx_delay_ticks) begin
        dly_on_ff <= 1'b0;
        holding_empty_flag_ff <= 1'b1;
        two_seen_ff <= 1'b0;
      end else begin
        dly_cnt_ff <= 8'(dly_cnt_ff + 8'h01);
      end
    end
  end
  assign holding_empty_flag_set = tx_empty && !dly_on_ff && !holding_empty_flag_ff &&
                    (two_seen_ff || !fifo_en);

  logic [3:0] iid_code;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      holding_empty_flag_irq_ff <= 1'b0;
    end else if (ien_ff[uart_pkg::IEN_HOLDING_EMPTY_FLAG_BIT] && (fifo_enable_bit_chg || holding_empty_flag_set || dly_done)) begin
      holding_empty_flag_irq_ff <= 1'b1;
    end else if (wr_thr || (rd_iid && iid_code == uart_pkg::IID_HOLDING_EMPTY_FLAG) ||
                 !ien_ff[uart_pkg::IEN_HOLDING_EMPTY_FLAG_BIT]) begin
      holding_empty_flag_irq_ff <= 1'b0;
    end
  end

  // ---------------------------------------------------------------
  // Interrupt identification
  // ---------------------------------------------------------------
  always_comb begin
    if (ls_hit) begin
      iid_code = uart_pkg::IID_RLS;
    end else if (rda_hit) begin
      iid_code = uart_pkg::IID_RDA;
    end else if (tmo_ff) begin
      iid_code = uart_pkg::IID_TMO;
    end else if (holding_empty_flag_irq_ff) begin
      iid_code = uart_pkg::IID_HOLDING_EMPTY_FLAG;
    end else begin
      iid_code = uart_pkg::IID_NONE;
    end
  end
  assign uart_irq = iid_code != uart_pkg::IID_NONE;

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [3:0] rd_idx;
  logic [7:0] rd_byte;
  logic rd_map;
  assign arready = !rvalid_ff;
  assign rd_go = arvalid && arready;
  assign rd_idx = araddr[5:2];
  assign rd_rbr = rd_go && rd_idx == uart_pkg::IDX_DATA && !latch_access_bit;
  assign rd_iid = rd_go && rd_idx == uart_pkg::IDX_IID;
  assign rd_lsr = rd_go && rd_idx == uart_pkg::IDX_LSTAT;
  always_comb begin
    rd_map = 1'b1;
    case (rd_idx)
      uart_pkg::IDX_DATA: rd_byte = latch_access_bit ? div_ff[7:0] : rx_data;
      uart_pkg::IDX_IEN: rd_byte = latch_access_bit ? div_ff[15:8] : ien_ff;
      uart_pkg::IDX_IID: rd_byte = {fifo_en ? uart_pkg::IID_FIFO_MARK : 2'h0, 2'h0, iid_code};
      uart_pkg::IDX_LCTL: rd_byte = lctl_ff;
      uart_pkg::IDX_LSTAT: rd_byte = {rx_fifo_err & fifo_en, holding_empty_flag_ff & tx_idle, holding_empty_flag_ff,
                                      rx_err_bits, dr_ff};
      uart_pkg::IDX_CFG: rd_byte = {7'h00, hs_ff};
      default: begin
        rd_byte = 8'h00;
        rd_map = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
      rresp_ff <= uart_pkg::RESP_OKAY;
    end else if (rd_go) begin
      rvalid_ff <= 1'b1;
      rdata_ff <= {24'h00_0000, rd_byte};
      rresp_ff <= rd_map ? uart_pkg::RESP_OKAY : uart_pkg::RESP_SLVERR;
    end else if (rready) begin
      rvalid_ff <= 1'b0;
    end
  end
  assign rvalid = rvalid_ff;
  assign rdata = rdata_ff;
  assign rresp = rresp_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  sequence idle_full_s;
    baud_tick && tmo_en && rx_level != 5'h00 && !rd_rbr && !rx_push &&
    tmo_cnt_ff >= tmo_limit;
  endsequence

  chk_latch_low_write: assert property (wr_div_lo |=> div_ff[7:0] == $past(wbyte_ff))
    else $error("divisor low byte not written");
  chk_data_trigger: assert property (rda_hit && !ls_hit |-> iid_code == uart_pkg::IID_RDA)
    else $error("trigger level did not report receive data");
  chk_ls_first: assert property (ls_hit |-> uart_irq && iid_code == uart_pkg::IID_RLS)
    else $error("line status not given priority");
  chk_ready_set: assert property (rx_push |=> dr_ff)
    else $error("data ready not set on push");
  chk_timeout_fire: assert property (idle_full_s |=> tmo_ff ##0 uart_irq)
    else $error("timeout not raised after idle time");
  chk_timeout_clear: assert property (tmo_ff && rd_rbr |=> !tmo_ff && tmo_cnt_ff == 10'h000)
    else $error("read did not clear timeout");
  chk_holding_empty_flag_write_clr: assert property (holding_empty_flag_irq_ff && wr_thr && !fifo_enable_bit_chg && !holding_empty_flag_set &&
    !dly_done |=> !holding_empty_flag_irq_ff)
    else $error("holding write did not clear interrupt");
  chk_fifo_toggle: assert property (fifo_enable_bit_chg && ien_ff[uart_pkg::IEN_HOLDING_EMPTY_FLAG_BIT]
    |=> holding_empty_flag_irq_ff)
    else $error("enable change did not raise transmit interrupt");
  chk_shared_prio: assert property (tmo_ff && !ls_hit && !rda_hit
    |-> iid_code == uart_pkg::IID_TMO)
    else $error("timeout not at data priority");
endmodule

// >>> shared/uart_pkg.sv
// Constants shared by the baud generator and the serial interrupt block
package uart_pkg;
  // ---------------------------------------------------------------
  // Clocking
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ = 250_000_000;
  localparam int unsigned OSC_HZ = 1_846_200;
  localparam int unsigned OSC_HALF_CYCLES = CLK_HZ / (2 * OSC_HZ);
  localparam int unsigned TICKS_PER_BIT = 16;
  localparam int unsigned TIMEOUT_CHARS = 4;
  localparam int unsigned DATA_BITS_MIN = 5;
  // ---------------------------------------------------------------
  // Register indexes; byte address is four times the index
  // ---------------------------------------------------------------
  localparam logic [3:0] IDX_DATA = 4'h0;
  localparam logic [3:0] IDX_IEN = 4'h1;
  localparam logic [3:0] IDX_IID = 4'h2;
  localparam logic [3:0] IDX_LCTL = 4'h3;
  localparam logic [3:0] IDX_LSTAT = 4'h5;
  localparam logic [3:0] IDX_CFG = 4'h8;
  // ---------------------------------------------------------------
  // Field positions and codes
  // ---------------------------------------------------------------
  localparam int unsigned LATCH_ACCESS_BIT = 7;
  localparam int unsigned PARITY_BIT = 3;
  localparam int unsigned STOP2_BIT = 2;
  localparam int unsigned IEN_RDA_BIT = 0;
  localparam int unsigned IEN_HOLDING_EMPTY_FLAG_BIT = 1;
  localparam int unsigned IEN_RLS_BIT = 2;
  localparam int unsigned FCR_EN_BIT = 0;
  localparam int unsigned FCR_RXRST_BIT = 1;
  localparam int unsigned FCR_TXRST_BIT = 2;
  localparam int unsigned CFG_HS_BIT = 0;
  localparam logic [3:0] IID_NONE = 4'h1;
  localparam logic [3:0] IID_RLS = 4'h6;
  localparam logic [3:0] IID_RDA = 4'h4;
  localparam logic [3:0] IID_TMO = 4'hc;
  localparam logic [3:0] IID_HOLDING_EMPTY_FLAG = 4'h2;
  localparam logic [1:0] IID_FIFO_MARK = 2'h3;
  localparam logic [4:0] TRIG_L0 = 5'h01;
  localparam logic [4:0] TRIG_L1 = 5'h04;
  localparam logic [4:0] TRIG_L2 = 5'h08;
  localparam logic [4:0] TRIG_L3 = 5'h0e;
  localparam logic [15:0] DIV_HS_X2 = 16'h8002;
  localparam logic [15:0] DIV_HS_X4 = 16'h8001;
  localparam logic [15:0] DIV_RESET = 16'h0000;
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// >>> rtl/baud_generator.sv
// Programmable 16x baud clock generator stepped by oscillator edges
`timescale 1ns/1ps
module baud_generator (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic osc_lvl,
  input wire logic osc_rise,
  input wire logic [15:0] divisor,
  input wire logic reload,
  output logic baud16,
  output logic baud_tick
);
  logic [15:0] cnt_ff;
  logic [15:0] n_div;
  logic [15:0] low_len;
  logic prev_ff;
  logic out_nxt;

  // ---------------------------------------------------------------
  // Count and waveform
  // ---------------------------------------------------------------
  always_comb begin
    n_div = (divisor == 16'h0000) ? 16'h0003 : divisor;
    low_len = (n_div == 16'h0002) ? 16'h0001 : 16'h0002;
    if (n_div == 16'h0001) begin
      out_nxt = ~osc_lvl;
    end else begin
      out_nxt = cnt_ff > low_len;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_ff <= 16'h0001;
    end else if (reload) begin
      cnt_ff <= 16'h0001;
    end else if (osc_rise) begin
      cnt_ff <= (cnt_ff >= n_div) ? 16'h0001 : 16'(cnt_ff + 16'h0001);
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      baud16 <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      baud16 <= out_nxt;
      prev_ff <= baud16;
    end
  end

  assign baud_tick = baud16 & ~prev_ff;

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  sequence low_phase_s;
    osc_rise && !reload && n_div >= 16'h0003 && cnt_ff == n_div;
  endsequence

  chk_reload_restart: assert property (@(posedge aclk) disable iff (!aresetn)
    reload |=> cnt_ff == 16'h0001)
    else $error("divisor write did not restart the count");
  chk_low_two_counts: assert property (@(posedge aclk) disable iff (!aresetn)
    low_phase_s |=> ##1 !baud16)
    else $error("output not low at start of period");
  chk_div1_inverse: assert property (@(posedge aclk) disable iff (!aresetn)
    n_div == 16'h0001 |=> baud16 == !$past(osc_lvl))
    else $error("divisor one output is not the inverted oscillator");
endmodule

// >>> tb/serial_peer.sv
// Behavioural receive and transmit FIFO side of the serial port
`timescale 1ns/1ps
module serial_peer (
  input wire logic aclk,
  input wire logic inject,
  input wire logic [7:0] inject_data,
  input wire logic rx_pop,
  input wire logic tx_push,
  input wire logic [7:0] tx_wdata,
  input wire logic rx_fifo_clear,
  input wire logic tx_fifo_clear,
  output logic rx_push = 0,
  output logic [4:0] rx_level = '0,
  output logic [7:0] rx_data = 8'hff,
  output logic [4:0] tx_level = '0,
  output logic tx_idle = 1,
  output logic [7:0] last_tx = '0
);
  logic [7:0] q[$];
  int txc = 0;
  int dr = 0;
  // -------------------------------------------------------------
  // Receive queue
  // -------------------------------------------------------------
  always @(posedge aclk) begin
    rx_push <= inject;
    if (rx_fifo_clear) begin
      q.delete();
    end else begin
      if (rx_pop && q.size() != 0) q.delete(0);
      if (inject) q.push_back(inject_data);
    end
    rx_level <= 5'(q.size());
    // Empty queue shows a changing pattern, the last byte and its inverse by turns
    rx_data <= q.size() != 0 ? q[0] : ~rx_data;
  end
  // -------------------------------------------------------------
  // Transmit queue, drains one byte every 64 clocks
  // -------------------------------------------------------------
  always @(posedge aclk) begin
    if (tx_fifo_clear) begin
      txc = 0;
    end else if (tx_push) begin
      txc++;
      last_tx <= tx_wdata;
    end else if (txc != 0) begin
      dr++;
      if (dr == 64) begin
        txc--;
        dr = 0;
      end
    end
    tx_level <= 5'(txc);
    tx_idle <= txc == 0;
  end
endmodule

// >>> tb/uart_baud_gen_fifo_irq_bench.sv
// Self-checking bench for the baud generator and FIFO interrupt block
`timescale 1ns/1ps
module uart_baud_gen_fifo_irq_bench;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, d, seed = 32'hac14;
  logic [3:0] wstrb = 4'hf, rx_err_bits = 4'h0;
  logic rx_fifo_err = 0, inject = 0, awready, wready, bvalid, arready, rvalid, rx_pop, tx_push;
  logic line_status_read, rx_fifo_clear, tx_fifo_clear, baud16, baud_tick, uart_irq, rx_push;
  logic tx_idle;
  logic [1:0] bresp, rresp, r;
  logic [4:0] rx_level, tx_level;
  logic [7:0] rx_data, tx_wdata, last_tx, inject_data = '0, b;
  int n_fail = 0, checked = 0, per, lo, n;
  int dl[5] = '{3, 2, 0, 5, 1};
  int mq[$];
  int n_lsr = 0, n_clr = 0;
  always #2 aclk = ~aclk;
  uart_baud_fifo_irq #(.OSC_HALF(4)) i_dut (.*);
  serial_peer i_peer (.*);
  // Line-status-read and FIFO-clear pulses are counted so that they are checked at the end
  always @(posedge aclk) begin
    n_lsr <= n_lsr + line_status_read;
    n_clr <= n_clr + rx_fifo_clear + tx_fifo_clear;
  end
  // -------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    n_fail++;
    wrap_up;
  endtask
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %0h seen %0h", what, e, g);
    end
  endtask
  function automatic logic [7:0] rnd;
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  task automatic wr(input logic [3:0] i, input logic [7:0] v);
    awaddr <= {i, 2'h0};
    wdata <= {24'h0, v};
    awvalid <= 1;
    wvalid <= 1;
    bready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 0;
      if (wready) wvalid <= 0;
      if (bvalid) break;
    end
    bready <= 0;
    @(posedge aclk);
    if (n == 99) hang;
  endtask
  task automatic rd(input logic [3:0] i);
    araddr <= {i, 2'h0};
    arvalid <= 1;
    rready <= 1;
    for (n = 0; n < 99; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 0;
      if (rvalid) break;
    end
    d = rdata;
    r = rresp;
    rready <= 0;
    @(posedge aclk);
    if (n == 99) hang;
  endtask
  task automatic rdc(input string what, input logic [3:0] i, input logic [31:0] m, e);
    rd(i);
    chk(what, e, d & m);
  endtask
  task automatic push;
    b = rnd();
    inject_data <= b;
    inject <= 1;
    mq.push_back(b);
    @(posedge aclk);
    inject <= 0;
  endtask
  // Period and low time of the 16x clock, from one rising edge to the next
  task automatic meas;
    lo = 0;
    for (n = 0; n < 999 && !baud_tick; n++) @(posedge aclk);
    @(posedge aclk);
    for (per = 1; per < 999 && !baud_tick; per++) begin
      lo += !baud16;
      @(posedge aclk);
    end
  endtask
  // -------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1;
    @(posedge aclk);
    rdc("iid", 2, 32'hff, 32'h01);
    wr(3, 8'h80);
    foreach (dl[k]) begin
      wr(0, 8'(dl[k]));
      wr(1, 8'h00);
      rdc("div_low", 0, 32'hff, dl[k]);
      meas;
      meas;
      chk("period", (dl[k] == 0 ? 3 : dl[k]) * 8, per);
      if (dl[k] != 0) chk("low", dl[k] == 1 ? 4 : dl[k] == 2 ? 8 : 16, lo);
    end
    wr(8, 8'h01);
    for (int h = 2; h <= 4; h += 2) begin
      wr(0, 8'(3 - h / 2));
      wr(1, 8'h80);
      meas;
      meas;
      chk("period_hs", 8 / h, per);
    end
    wr(8, 8'h00);
    wr(1, 8'h00);
    wr(3, 8'h00);
    rd(15);
    chk("resp", uart_pkg::RESP_SLVERR, r);
    $display("test baud done");
    wr(2, 8'h01);
    wr(1, 8'h01);
    push;
    @(posedge aclk);
    rdc("ready", 5, 1, 1);
    wr(1, 8'h05);
    rx_err_bits <= 4'(rnd() | 8'h01);
    rdc("iid", 2, 32'hff, 32'hc6);
    rx_err_bits <= 4'h0;
    rdc("iid", 2, 32'hff, 32'hc4);
    rdc("data", 0, 32'hff, mq.pop_front());
    rdc("iid", 2, 32'hff, 32'hc1);
    rdc("ready", 5, 1, 0);
    $display("test trigger done");
    wr(2, 8'h81);
    push;
    for (n = 0; n < 4000 && !uart_irq; n++) @(posedge aclk);
    chk("tmo_wait", 1, n > 3550 && n < 3620);
    rdc("iid", 2, 32'hff, 32'hcc);
    rdc("data", 0, 32'hff, mq.pop_front());
    rdc("iid", 2, 32'hff, 32'hc1);
    $display("test timeout done");
    wr(1, 8'h02);
    wr(2, 8'h00);
    rdc("iid", 2, 32'hff, 32'h02);
    rdc("iid", 2, 32'hff, 32'h01);
    wr(2, 8'h01);
    rdc("iid", 2, 32'hff, 32'hc2);
    wr(0, rnd());
    rdc("iid", 2, 32'hff, 32'hc1);
    chk("tx_byte", wdata[7:0], last_tx);
    for (n = 0; n < 2000 && !uart_irq; n++) @(posedge aclk);
    chk("holding_empty_flag_dly", 1, n > 790 && n < 860);
    wr(0, rnd());
    rdc("iid", 2, 32'hff, 32'hc1);
    chk("lsr_reads", 2, n_lsr);
    chk("fifo_clears", 6, n_clr);
    $display("test transmit done");
    wrap_up;
  end
  initial begin
    repeat (60000) @(posedge aclk);
    hang;
  end
endmodule
